//--- rtl/plt_pkg.sv
// Constants shared by the physical-layer link training control registers.
// Assumes a 100 MHz core clock and a 12-bit byte address on the register port.
`default_nettype none

package plt_pkg;

    // ------------------------------------------------------------------
    // Register port geometry and register offsets
    // ------------------------------------------------------------------
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 32;
    localparam logic [11:0] CFG_OFFSET   = 12'h530;
    localparam logic [11:0] STATE_OFFSET = 12'h540;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          GEN1_BIT              = 8;
    localparam int          XLINK_BIT             = 11;
    localparam int          POLICY_BIT            = 14;
    localparam int          RETRAIN_BIT           = 31;
    localparam logic [31:0] CFG_RW_MASK           = 32'h0000_4900;
    localparam logic        GEN1_RESET            = 1'h0;
    localparam logic        XLINK_RESET           = 1'h0;
    localparam logic        POLICY_RST_DOWNSTREAM = 1'h0;
    localparam logic        POLICY_RST_OTHER      = 1'h1;
    localparam logic        POLICY_AUTOMATIC      = 1'h0;

    // ------------------------------------------------------------------
    // Training ordered-set control bits seen by the physical layer
    // ------------------------------------------------------------------
    localparam int          TS_W          = 8;
    localparam logic [7:0]  TS_GEN1_MASK  = 8'h0F;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS        = 10;
    localparam int RETRAIN_DELAY_NS     = 1000000;
    localparam int RETRAIN_DELAY_CYCLES = (RETRAIN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W              = 17;

    // Retrain sequencer states.
    typedef enum logic [2:0] {
        RT_IDLE  = 3'h1,
        RT_ACKED = 3'h2,
        RT_DELAY = 3'h4
    } plt_retrain_state_type;

endpackage

`default_nettype wire

//--- rtl/plt_reset_sync.sv
// Reset synchroniser: asserts at once, releases after two clock edges.
// Assumes the raw reset is active low and may arrive at any time.
`timescale 1ns/1ps
`default_nettype none

module plt_reset_sync (
    input  wire logic clk,
    input  wire logic rst_b,
    output var  logic rst_sync_b
);
    import plt_pkg::*;

    logic stage1;

    // ------------------------------------------------------------------
    // Two-flop release
    // ------------------------------------------------------------------
    // Only constants enter under reset, so release never glitches.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1     <= 1'h0;
            rst_sync_b <= 1'h0;
        end else begin
            stage1     <= 1'h1;
            rst_sync_b <= stage1;
        end
    end

endmodule

`default_nettype wire

//--- rtl/plt_delay_timer.sv
// One-shot down counter that flags expiry a fixed number of cycles after start.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module plt_delay_timer #(
    parameter int CYCLES = plt_pkg::RETRAIN_DELAY_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_int_b,
    input  wire logic start,
    output var  logic expire
);
    import plt_pkg::*;

    logic [TIMER_W-1:0] cnt;
    logic [TIMER_W-1:0] next_cnt;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // A start while running reloads, so the delay is always measured from the last start.
    always_comb begin
        next_cnt = cnt;
        if (start) begin
            next_cnt = TIMER_W'(CYCLES);
        end else if (cnt != '0) begin
            next_cnt = cnt - TIMER_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    // Expiry is flagged in the last counted cycle.
    assign expire = (cnt == TIMER_W'(1));

endmodule

`default_nettype wire

//--- rtl/plt_ctrl_regs.sv
// Physical-layer link training control registers of one switch port.
// Assumes the LTSSM, the port mode straps and the register master share clk.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module plt_ctrl_regs #(
    parameter int RETRAIN_DELAY_CYCLES = plt_pkg::RETRAIN_DELAY_CYCLES
) (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    input  wire logic [plt_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [plt_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output var  logic [plt_pkg::DATA_W-1:0] reg_rdata,
    output var  logic                       reg_wr_done,
    input  wire logic                       port_is_downstream,
    input  wire logic                       port_is_upstream,
    input  wire logic                       ltssm_in_detect,
    input  wire logic                       ltssm_in_l0,
    input  wire logic                       gen2_permitted,
    input  wire logic [plt_pkg::TS_W-1:0]   ts_ctrl_raw,
    output var  logic [plt_pkg::TS_W-1:0]   ts_ctrl_out,
    output var  logic                       gen1_compat_enable,
    output var  logic                       crosslink_disable,
    output var  logic                       speed_change_req,
    output var  logic                       retrain_to_detect
);
    import plt_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                  rst_int_b;
    logic                  cfg_wr;
    logic                  state_wr;
    logic                  retrain_wr;
    logic                  cfg_loaded;
    logic                  next_cfg_loaded;
    logic                  next_gen1;
    logic                  next_xlink;
    logic                  initial_speed_change_policy;
    logic                  next_policy;
    logic [DATA_W-1:0]     next_rdata;
    logic                  next_wr_done;
    plt_retrain_state_type rt_state;
    plt_retrain_state_type next_rt_state;
    logic                  next_retrain;
    logic                  timer_start;
    logic                  timer_expire;
    logic                  speed_armed;
    logic                  next_speed_armed;
    logic                  next_speed_req;
    logic [TS_W-1:0]       next_ts;

    // ------------------------------------------------------------------
    // Reset release and delay timer
    // ------------------------------------------------------------------
    plt_reset_sync u_reset_sync (
        .clk        (clk),
        .rst_b      (rst_b),
        .rst_sync_b (rst_int_b)
    );

    plt_delay_timer #(
        .CYCLES (RETRAIN_DELAY_CYCLES)
    ) u_delay_timer (
        .clk       (clk),
        .rst_int_b (rst_int_b),
        .start     (timer_start),
        .expire    (timer_expire)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Full 12-bit compare so aliases of either register never respond.
    assign cfg_wr     = reg_wr && (reg_addr == CFG_OFFSET);
    assign state_wr   = reg_wr && (reg_addr == STATE_OFFSET);
    assign retrain_wr = state_wr && reg_wdata[RETRAIN_BIT];

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    // The policy reset value depends on the port mode, which is only a level on an input,
    // so it is caught in the first cycle after release rather than under reset.
    // A write in that one cycle is dropped; software cannot reach it in time anyway.
    always_comb begin
        next_gen1       = gen1_compat_enable;
        next_xlink      = crosslink_disable;
        next_policy     = initial_speed_change_policy;
        next_cfg_loaded = 1'h1;
        if (!cfg_loaded) begin
            next_policy = port_is_downstream ? POLICY_RST_DOWNSTREAM
                                             : POLICY_RST_OTHER;
        end else if (cfg_wr) begin
            next_gen1   = reg_wdata[GEN1_BIT];
            next_xlink  = reg_wdata[XLINK_BIT];
            next_policy = reg_wdata[POLICY_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            gen1_compat_enable          <= GEN1_RESET;
            crosslink_disable           <= XLINK_RESET;
            initial_speed_change_policy <= POLICY_RST_OTHER;
            cfg_loaded                  <= 1'h0;
        end else begin
            gen1_compat_enable          <= next_gen1;
            crosslink_disable           <= next_xlink;
            initial_speed_change_policy <= next_policy;
            cfg_loaded                  <= next_cfg_loaded;
        end
    end

    // ------------------------------------------------------------------
    // Read data and write completion
    // ------------------------------------------------------------------
    // Read data stand for exactly one cycle; unmapped addresses and reserved bits give zero.
    always_comb begin
        next_rdata   = 32'h0000_0000;
        next_wr_done = reg_wr;
        if (reg_rd && (reg_addr == CFG_OFFSET)) begin
            next_rdata[GEN1_BIT]   = gen1_compat_enable;
            next_rdata[XLINK_BIT]  = crosslink_disable;
            next_rdata[POLICY_BIT] = initial_speed_change_policy;
        end
        // The state register holds only the self-clearing retrain bit, which reads zero.
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            reg_rdata   <= 32'h0000_0000;
            reg_wr_done <= 1'h0;
        end else begin
            reg_rdata   <= next_rdata;
            reg_wr_done <= next_wr_done;
        end
    end

    // ------------------------------------------------------------------
    // Retrain sequencer
    // ------------------------------------------------------------------
    // The completion pulse leaves one cycle before the earliest retrain, so the answer
    // is never lost to a link that is already going down. Requests while busy are ignored.
    always_comb begin
        next_rt_state = rt_state;
        next_retrain  = 1'h0;
        timer_start   = 1'h0;
        case (rt_state)
            RT_IDLE: begin
                if (retrain_wr) begin
                    if (port_is_upstream) begin
                        next_rt_state = RT_DELAY;
                        timer_start   = 1'h1;
                    end else begin
                        next_rt_state = RT_ACKED;
                    end
                end
            end
            RT_ACKED: begin
                next_retrain  = 1'h1;
                next_rt_state = RT_IDLE;
            end
            RT_DELAY: begin
                if (timer_expire) begin
                    next_retrain  = 1'h1;
                    next_rt_state = RT_IDLE;
                end
            end
            default: begin
                next_rt_state = RT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            rt_state          <= RT_IDLE;
            retrain_to_detect <= 1'h0;
        end else begin
            rt_state          <= next_rt_state;
            retrain_to_detect <= next_retrain;
        end
    end

    // ------------------------------------------------------------------
    // Automatic speed change and training set masking
    // ------------------------------------------------------------------
    // Arming on Detect and firing on the first L0 gives at most one request per training cycle.
    always_comb begin
        next_speed_armed = speed_armed;
        next_speed_req   = 1'h0;
        next_ts          = ts_ctrl_raw;
        if (retrain_to_detect || ltssm_in_detect) begin
            next_speed_armed = 1'h1;
        end else if (speed_armed && ltssm_in_l0) begin
            next_speed_armed = 1'h0;
            if ((initial_speed_change_policy == POLICY_AUTOMATIC) && gen2_permitted) begin
                next_speed_req = 1'h1;
            end
        end
        if (gen1_compat_enable) begin
            next_ts = ts_ctrl_raw & TS_GEN1_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            speed_armed      <= 1'h0;
            speed_change_req <= 1'h0;
            ts_ctrl_out      <= 8'h00;
        end else begin
            speed_armed      <= next_speed_armed;
            speed_change_req <= next_speed_req;
            ts_ctrl_out      <= next_ts;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Cycles spent in the delay state, read only by the checks below.
    int dly_cnt;
    always_ff @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            dly_cnt <= 0;
        end else begin
            dly_cnt <= (rt_state == RT_DELAY) ? dly_cnt + 1 : 0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_int_b);

    // Configuration fields and training set masking follow the register one cycle later.
    a_gen1_mode_set: assert property (cfg_wr && cfg_loaded |=>
        gen1_compat_enable == $past(reg_wdata[GEN1_BIT]))
        else $error("gen1 mode does not follow config write");
    a_gen1_ts_mask: assert property (gen1_compat_enable |=>
        (ts_ctrl_out & ~TS_GEN1_MASK) == 8'h00)
        else $error("undefined training bits set in gen1 mode");
    a_xlink_ctrl_set: assert property (cfg_wr && cfg_loaded |=>
        crosslink_disable == $past(reg_wdata[XLINK_BIT]))
        else $error("crosslink disable does not follow config write");

    // Speed change requests and the mode dependent policy reset value.
    a_speed_req_cause: assert property (speed_change_req |->
        $past(speed_armed && ltssm_in_l0 && gen2_permitted && !ltssm_in_detect))
        else $error("speed change request without first L0");
    a_no_auto_speed: assert property (initial_speed_change_policy |=>
        !speed_change_req)
        else $error("speed change request under nochange policy");
    a_policy_reset: assert property (!cfg_loaded |=>
        initial_speed_change_policy ==
        ($past(port_is_downstream) ? POLICY_RST_DOWNSTREAM : POLICY_RST_OTHER))
        else $error("policy reset value wrong for port mode");

    // Retrain sequencing: the completion always leads, the pulse follows the port's delay.
    a_retrain_down: assert property (
        retrain_wr && !port_is_upstream && rt_state == RT_IDLE |->
        ##1 !retrain_to_detect ##1 retrain_to_detect)
        else $error("downstream retrain not issued two cycles after write");
    a_retrain_reads_zero: assert property (
        reg_rd && reg_addr == STATE_OFFSET |=>
        reg_rdata == 32'h0000_0000)
        else $error("retrain bit read back nonzero");
    a_ack_before_retrain: assert property (retrain_wr && rt_state == RT_IDLE |=>
        reg_wr_done && !retrain_to_detect)
        else $error("retrain took effect before completion");
    a_upstream_delay: assert property (rt_state == RT_DELAY |->
        (dly_cnt < RETRAIN_DELAY_CYCLES) &&
        (!timer_expire || dly_cnt == RETRAIN_DELAY_CYCLES - 1))
        else $error("upstream retrain delay wrong");

    // Decode and reserved bits on the read path.
    a_cfg_decode: assert property (reg_rd && reg_addr == CFG_OFFSET |=>
        reg_rdata[POLICY_BIT] == $past(initial_speed_change_policy))
        else $error("config register read mismatch");
    a_reserved_zero: assert property (reg_rd |=>
        (reg_rdata & ~CFG_RW_MASK) == 32'h0000_0000)
        else $error("reserved bits read nonzero");

    c_retrain_down: cover property (retrain_wr && !port_is_upstream ##2 retrain_to_detect);
    c_retrain_up: cover property (rt_state == RT_DELAY && timer_expire ##1 retrain_to_detect);
    c_speed_req: cover property (speed_change_req);
    c_cfg_read: cover property (reg_rd && reg_addr == CFG_OFFSET ##1 reg_rdata[POLICY_BIT]);
    c_gen1_mask: cover property (gen1_compat_enable && ts_ctrl_raw[7:4] != 4'h0);

endmodule

`default_nettype wire

//--- tb/plt_link_model.sv
// Link-side stand-in: a small LTSSM that trains on command or after a retrain pulse.
// Assumes the same clock and raw reset as the register block.
`timescale 1ns/1ps
`default_nettype none

module plt_link_model (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic                     train,
    input  wire logic                     retrain_to_detect,
    output var  logic                     ltssm_in_detect,
    output var  logic                     ltssm_in_l0,
    output var  logic [plt_pkg::TS_W-1:0] ts_ctrl_raw
);
    logic [2:0] dwell;

    // ------------------------------------------------------------------
    // Training walk
    // ------------------------------------------------------------------
    // Detect stands three cycles so arming is seen, then L0 stands until the next walk.
    // The set bits move every cycle so a stale register cannot pass for a fresh one.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dwell <= 3'h0;
            ltssm_in_detect <= 1'b0;
            ltssm_in_l0 <= 1'b0;
            ts_ctrl_raw <= 8'hA5;
        end else begin
            ts_ctrl_raw <= ts_ctrl_raw + 8'h5B;
            if (train || retrain_to_detect) begin
                dwell <= 3'h3;
                ltssm_in_detect <= 1'b1;
                ltssm_in_l0 <= 1'b0;
            end else if (dwell != 3'h0) begin
                dwell <= dwell - 3'h1;
                if (dwell == 3'h1) begin
                    ltssm_in_detect <= 1'b0;
                    ltssm_in_l0 <= 1'b1;
                end
            end
        end
    end
endmodule

`default_nettype wire

//--- tb/test_phy_link_training_control_regs.sv
// Self-checking bench for the link training control registers.
// Assumes a 10 ns clock and a shortened upstream retrain delay.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin failures++; \
    $display("wrong value at %0t ns: %s", $time, msg); end end

module test_phy_link_training_control_regs;
    import plt_pkg::*;
    localparam int DLY = 20;
    logic        clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, ds = 1, us = 0;
    logic        gen2 = 1, train = 0, ts_on = 0;
    logic        wr_done, gen1, xlink, sc_req, rt, det, l0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata, mcfg, d;
    logic [7:0]  ts_raw, ts_out, exp_ts;
    logic [15:0] lfsr = 16'h49BF; // Seed 18879.
    int          failures = 0, compares = 0, sc_cnt = 0, rt_cnt = 0, exp_sc = 0;
    time         t1;

    plt_ctrl_regs #(.RETRAIN_DELAY_CYCLES(DLY)) DUT (.clk(clk), .rst_b(rst_b),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata), .reg_wr_done(wr_done), .port_is_downstream(ds),
        .port_is_upstream(us), .ltssm_in_detect(det), .ltssm_in_l0(l0),
        .gen2_permitted(gen2), .ts_ctrl_raw(ts_raw), .ts_ctrl_out(ts_out),
        .gen1_compat_enable(gen1), .crosslink_disable(xlink),
        .speed_change_req(sc_req), .retrain_to_detect(rt));
    plt_link_model link (.clk(clk), .rst_b(rst_b), .train(train), .retrain_to_detect(rt),
        .ltssm_in_detect(det), .ltssm_in_l0(l0), .ts_ctrl_raw(ts_raw));

    // Free-running clock.
    always #5 clk = ~clk;

    // ------------------------------------------------------------------
    // Monitors
    // ------------------------------------------------------------------
    // Pulse counters and the masked training bits, judged against pre-edge values.
    always @(posedge clk) begin
        if (sc_req === 1'b1) sc_cnt++;
        if (rt === 1'b1) rt_cnt++;
        if (ts_on) `CHK(ts_out, exp_ts, "training bits")
        exp_ts <= gen1 ? (ts_raw & TS_GEN1_MASK) : ts_raw;
    end

    // Sixteen-bit shift register, two steps per random word.
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic rnd32(output logic [31:0] r);
        lfsr = step(lfsr);
        r[15:0] = lfsr;
        lfsr = step(lfsr);
        r[31:16] = lfsr;
    endtask

    // ------------------------------------------------------------------
    // Bus and sequence tasks
    // ------------------------------------------------------------------
    // A write is one strobe cycle; the completion must stand in the next cycle.
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
        `CHK(wr_done, 1'b1, "write completion")
        if (a == CFG_OFFSET) mcfg = v & CFG_RW_MASK;
    endtask

    // Read data is looked at only in the cycle after the strobe.
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        #1;
        `CHK(rdata, e, "read data")
    endtask

    task automatic do_reset(input logic s);
        ts_on = 0;
        @(posedge clk);
        ds <= s;
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        mcfg = s ? 32'h0000_0000 : 32'h0000_4000;
        ts_on = 1;
    endtask

    // One walk from Detect to L0; a request comes only under the automatic policy.
    // The expectation is formed after an edge, so a permission change just made is seen.
    task automatic train_chk;
        @(posedge clk);
        exp_sc += (mcfg[14] == 1'b0 && gen2) ? 1 : 0;
        train <= 1'b1;
        @(posedge clk);
        train <= 1'b0;
        repeat (9) @(posedge clk);
        #1;
        `CHK(sc_cnt, exp_sc, "speed change count")
    endtask

    // Retrain from the write to the pulse; a second request while pending is dropped.
    // The delay counts cycles from the completion cycle to the pulse cycle, both included.
    task automatic retrain(input int exp_n);
        int c0;
        int g;
        c0 = rt_cnt;
        wr(STATE_OFFSET, 32'h8000_0000);
        t1 = $time;
        `CHK(rt, 1'b0, "retrain before completion")
        if (exp_n > 4) wr(STATE_OFFSET, 32'hFFFF_FFFF);
        g = 0;
        while (rt !== 1'b1 && g < 300) begin
            @(posedge clk);
            #1;
            g++;
        end
        `CHK(int'(($time - t1) / 10) + 1, exp_n, "retrain delay")
        exp_sc += (mcfg[14] == 1'b0 && gen2) ? 1 : 0;
        repeat (10) @(posedge clk);
        #1;
        `CHK(rt_cnt - c0, 1, "retrain count")
        `CHK(sc_cnt, exp_sc, "speed change after retrain")
        rd(STATE_OFFSET, 32'h0000_0000);
    endtask

    task automatic tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        do_reset(1'b1);
        rd(CFG_OFFSET, 32'h0000_0000);
        $display("test reset_downstream finished");
        for (int i = 0; i < 10; i++) begin
            rnd32(d);
            if (i == 0) d = 32'hFFFF_FFFF;
            wr(CFG_OFFSET, d);
            rd(CFG_OFFSET, mcfg);
            `CHK(gen1, mcfg[8], "compat output")
            `CHK(xlink, mcfg[11], "crosslink output")
        end
        wr(12'h534, 32'hFFFF_FFFF);
        rd(12'h534, 32'h0000_0000);
        rd(CFG_OFFSET, mcfg);
        $display("test config_fields finished");
        wr(CFG_OFFSET, 32'h0000_0100);
        train_chk();
        gen2 <= 1'b0;
        train_chk();
        gen2 <= 1'b1;
        wr(CFG_OFFSET, 32'h0000_4100);
        train_chk();
        $display("test speed_policy finished");
        wr(CFG_OFFSET, 32'h0000_0100);
        retrain(2);
        us <= 1'b1;
        // The pulse is registered DLY edges after the write edge.
        retrain(DLY + 1);
        us <= 1'b0;
        $display("test retrain finished");
        do_reset(1'b0);
        rd(CFG_OFFSET, 32'h0000_4000);
        train_chk();
        $display("test reset_other finished");
        tally_and_finish();
    end

    // Watchdog well beyond the fewer than two hundred cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("wrong value at %0t ns: watchdog", $time);
        tally_and_finish();
    end
endmodule

`default_nettype wire
